// ### drcb_top.sv
// registered command/address buffer, 25 by one or 14 by two
// assumes: link clock and pins arrive asynchronously and are oversampled by sys_clk
`timescale 1ns/10ps
`default_nettype none
module drcb_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic deviceResetN,
  input wire logic linkClk,
  input wire logic [27:0] dataIn,
  input wire logic secondChipSelectInN,
  input wire logic fanoutSelect,
  input wire logic abBankSelect,
  input wire logic loadReady,
  output logic [13:0] copyAOut,
  output logic [13:0] copyBOut,
  output logic wordValid,
  output logic captureReady
);
  drcb_pkg::drcb_core_t st_r;
  drcb_pkg::drcb_core_t st_nxt;
  logic arst;
  logic clkRise;
  logic oneToTwo;
  logic bankB;
  logic [13:0] gateCol1;
  logic [13:0] gateColB;
  logic [13:0] outMaskB;
  logic [27:0] usedMask;
  logic [13:0] newA;
  logic [13:0] newB;
  logic popFire;
  drcb_pkg::drcb_word_t capWord;
  drcb_pkg::drcb_word_t outWord;

  drcb_stream_if #(.W(drcb_pkg::WORD_W)) capIf ();
  drcb_stream_if #(.W(drcb_pkg::WORD_W)) outIf ();

  // ==========================================================
  // reset: either the core reset or the device pin clears everything at once
  assign arst = rst | ~deviceResetN;

  // ==========================================================
  // strap decode, applied straight to the mapping
  assign oneToTwo = st_r.strapSync[1];
  assign bankB = st_r.strapSync[0];

  // gated positions of column one and of the second output column
  always_comb begin
    if (oneToTwo && bankB) begin
      gateCol1 = drcb_pkg::GATE_B_MASK;
    end else begin
      gateCol1 = drcb_pkg::GATE_A_MASK;
    end
    if (oneToTwo) begin
      gateColB = gateCol1;
      outMaskB = drcb_pkg::ALL_MASK;
      usedMask = {14'h0000, drcb_pkg::ALL_MASK};
    end else begin
      gateColB = drcb_pkg::COL2_USED_MASK;
      outMaskB = drcb_pkg::COL2_USED_MASK;
      usedMask = {drcb_pkg::COL2_USED_MASK, drcb_pkg::ALL_MASK};
    end
  end

  // ==========================================================
  // capture side: rising link clock edge seen after the synchronisers
  assign clkRise = st_r.clkSync && !st_r.clkPrev;
  // freeze flag when both select pins stand high, then the masked word
  assign capWord = {st_r.dataSync[drcb_pkg::CS_POS] && st_r.sel2Sync, st_r.dataSync & usedMask};
  assign capIf.valid = clkRise && st_r.rxOn;
  assign capIf.data = capWord;

  // two-entry buffer between capture and output register
  drcb_fifo2 #(
    .W(drcb_pkg::WORD_W)
  ) u_buf (
    .sys_clk(sys_clk),
    .arst(arst),
    .fillSide(capIf),
    .drainSide(outIf)
  );

  // ==========================================================
  // output side: loads drain only while the load side is ready
  assign outIf.ready = loadReady;
  assign popFire = outIf.valid && loadReady;
  assign outWord = outIf.data;
  assign newA = outWord.bits[13:0];
  assign newB = oneToTwo ? outWord.bits[13:0] : outWord.bits[27:14];

  // ==========================================================
  // next-state logic for synchronisers, receiver enable and outputs
  always_comb begin
    st_nxt = st_r;
    // reset release and receiver activation
    st_nxt.rstPipe = {st_r.rstPipe[0], 1'b1};
    if (st_r.rstPipe[1] && !st_r.rxOn) begin
      if (st_r.actCnt == 3'(drcb_pkg::RX_ACT_CYC - 1)) begin
        st_nxt.rxOn = 1'b1;
      end else begin
        st_nxt.actCnt = st_r.actCnt + 3'h1;
      end
    end
    // two-flop synchronisers, the first stage feeds only the second
    st_nxt.clkMeta = linkClk;
    st_nxt.clkSync = st_r.clkMeta;
    st_nxt.clkPrev = st_r.clkSync;
    st_nxt.dataMeta = dataIn;
    st_nxt.dataSync = st_r.dataMeta;
    st_nxt.sel2Meta = secondChipSelectInN;
    st_nxt.sel2Sync = st_r.sel2Meta;
    st_nxt.strapMeta = {fanoutSelect, abBankSelect};
    st_nxt.strapSync = st_r.strapMeta;
    // output registers load from the buffer, else hold
    st_nxt.wordValid = popFire;
    st_nxt.captureReady = capIf.ready && st_r.rxOn;
    if (popFire) begin
      if (outWord.holdReq) begin
        st_nxt.copyA = (st_r.copyA & gateCol1) | (newA & ~gateCol1);
        st_nxt.copyB = ((st_r.copyB & gateColB) | (newB & ~gateColB)) & outMaskB;
      end else begin
        st_nxt.copyA = newA;
        st_nxt.copyB = newB & outMaskB;
      end
    end else begin
      st_nxt.copyA = st_r.copyA;
      st_nxt.copyB = st_r.copyB & outMaskB;
    end
  end

  // ==========================================================
  // single state register, cleared without the clock
  always_ff @(posedge sys_clk or posedge arst) begin
    if (arst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs straight from the state register
  assign copyAOut = st_r.copyA;
  assign copyBOut = st_r.copyB;
  assign wordValid = st_r.wordValid;
  assign captureReady = st_r.captureReady;

  // ==========================================================
  // checks
  chk_reset_forces_low: assert property (@(posedge sys_clk) disable iff (rst)
    !deviceResetN |-> (copyAOut == drcb_pkg::OUT_RESET) && (copyBOut == drcb_pkg::OUT_RESET)
      && !wordValid) else $error("outputs not low in reset");

  chk_pad_low: assert property (@(posedge sys_clk) disable iff (arst)
    (!oneToTwo && $past(!oneToTwo)) |-> (copyBOut[0] == 1'b0) && (copyBOut[3] == 1'b0)
      && (copyBOut[6] == 1'b0)) else $error("one-to-one pad driven high");

  chk_copies_match: assert property (@(posedge sys_clk) disable iff (arst)
    (wordValid && oneToTwo && $past(oneToTwo) && $past(oneToTwo, 2)) |-> (copyAOut == copyBOut))
    else $error("one-to-two copies differ");

  chk_gated_freeze: assert property (@(posedge sys_clk) disable iff (arst)
    (popFire && outWord.holdReq && $stable(st_r.strapSync))
      |=> ((copyAOut & gateCol1) == $past(copyAOut & gateCol1)))
    else $error("gated output changed while both selects high");

  chk_gated_load: assert property (@(posedge sys_clk) disable iff (arst)
    (popFire && !outWord.holdReq) |=> (copyAOut == $past(newA)))
    else $error("gated output missed a load");

  chk_control_load: assert property (@(posedge sys_clk) disable iff (arst)
    popFire |=> ((copyAOut & ~gateCol1) == ($past(newA) & ~gateCol1)))
    else $error("control output frozen");

  chk_rx_wait: assert property (@(posedge sys_clk) disable iff (arst)
    !st_r.rxOn |-> !capIf.valid) else $error("capture before receivers enabled");

  chk_rx_release_time: assert property (@(posedge sys_clk) disable iff (arst)
    $rose(st_r.rstPipe[1]) |-> !st_r.rxOn [*3] ##1 st_r.rxOn)
    else $error("receiver enable time wrong");

  chk_edge_capture: assert property (@(posedge sys_clk) disable iff (arst)
    (clkRise && st_r.rxOn && !outIf.valid) |=> outIf.valid && (outIf.data == $past(capIf.data)))
    else $error("rising edge not captured");

  chk_idle_hold: assert property (@(posedge sys_clk) disable iff (arst)
    (!popFire && $stable(st_r.strapSync)) |=> $stable(copyAOut))
    else $error("output moved without a load");

  chk_unused_ignored: assert property (@(posedge sys_clk) disable iff (arst)
    (capIf.valid && oneToTwo) |-> (capWord.bits[27:14] == 14'h0000))
    else $error("unused column captured");

  chk_b_controls: assert property (@(posedge sys_clk) disable iff (arst)
    (popFire && outWord.holdReq && oneToTwo && bankB && $stable(st_r.strapSync))
      |=> (copyAOut[13] == $past(newA[13])) && (copyAOut[10] == $past(newA[10]))
      && (copyAOut[0] == $past(copyAOut[0])))
    else $error("arrangement B control positions wrong");
endmodule : drcb_top
`default_nettype wire

// ### drcb_pkg.sv
// constants and types shared by the registered command buffer files
// assumes: sys_clk at 250 MHz; input column indices follow pin rows 1..14
//
// Behaviour
// - capture every active data input on each rising edge of the link clock (here an edge is dropped while two words fill the buffer)
// - fanout strap low gives 25 bits one-to-one, high gives 14 bits one-to-two
// - in one-to-two, bank strap picks arrangement A when low, B when high
// - one-to-one mode drives the three unused last-column outputs low
// - device reset acts asynchronously, no timing to the clock needed
// - while device reset is low, all registers clear and all outputs are low
// - while device reset is low, input receivers ignore data, clock and selects
// - after reset rises, outputs stay low until receivers are fully enabled
// - both chip selects high freeze gated outputs; otherwise gated outputs load
// - reset overrides chip-select freezing and forces outputs low
// - clock enable, termination and chip select outputs load on every edge (here on each word drained from the buffer)
// - gated inputs are all positions except the three control positions
// - only outputs tied to gated inputs are frozen by chip selects
// - one-to-one: input n drives output n; controls at 1, 4, 7
// - one-to-two A: input n drives both copies; controls at 1, 4, 7
// - one-to-two B: clock enable at 14, termination at 11, select at 7
// - unused positions ignore their inputs and hold their outputs low
// - two widths and fan-outs: 25 by one, or 14 by two
package drcb_pkg;
  // ==========================================================
  // geometry
  localparam int COL_W = 14;
  localparam int IN_W = 28;
  localparam int WORD_W = 29;
  // ==========================================================
  // position masks, bit i is row position i+1
  localparam logic [13:0] ALL_MASK = 14'h3fff;
  localparam logic [13:0] COL2_USED_MASK = 14'h3fb6; // column two minus the three pads
  localparam logic [13:0] GATE_A_MASK = 14'h3fb6; // controls at 1, 4, 7
  localparam logic [13:0] GATE_B_MASK = 14'h1bbf; // controls at 7, 11, 14
  localparam int CS_POS = 6; // chip select row, all modes
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int RX_ACT_PS = 10000; // receiver activation time
  localparam int RX_ACT_CYC = (RX_ACT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // ==========================================================
  // reset values
  localparam logic [13:0] OUT_RESET = 14'h0000;
  // ==========================================================
  // types
  typedef struct packed {
    logic holdReq; // both chip selects were high at capture
    logic [27:0] bits; // masked column two & column one
  } drcb_word_t;

  typedef struct packed {
    logic [1:0] rstPipe;
    logic [2:0] actCnt;
    logic rxOn;
    logic clkMeta;
    logic clkSync;
    logic clkPrev;
    logic [27:0] dataMeta;
    logic [27:0] dataSync;
    logic sel2Meta;
    logic sel2Sync;
    logic [1:0] strapMeta;
    logic [1:0] strapSync;
    logic [13:0] copyA;
    logic [13:0] copyB;
    logic wordValid;
    logic captureReady;
  } drcb_core_t;
endpackage : drcb_pkg

// ### drcb_stream_if.sv
// valid/ready word channel between capture, buffer and output stage
// assumes: one clock domain, word taken when valid and ready are both high
`timescale 1ns/10ps
`default_nettype none
interface drcb_stream_if #(parameter int W = 29);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : drcb_stream_if
`default_nettype wire

// ### drcb_fifo2.sv
// two-entry word buffer with valid/ready on both sides
// assumes: synchronous to sys_clk, cleared by the combined async reset
`timescale 1ns/10ps
`default_nettype none
module drcb_fifo2 #(
  parameter int W = 29
) (
  input wire logic sys_clk,
  input wire logic arst,
  drcb_stream_if.snk fillSide,
  drcb_stream_if.src drainSide
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic wrPtr;
    logic rdPtr;
    logic [1:0] count;
  } drcb_fifo_t;

  drcb_fifo_t st_r;
  drcb_fifo_t st_nxt;
  logic pushFire;
  logic popFire;

  // ==========================================================
  // handshakes
  assign fillSide.ready = (st_r.count != 2'h2);
  assign drainSide.valid = (st_r.count != 2'h0);
  assign drainSide.data = st_r.mem[st_r.rdPtr];
  assign pushFire = fillSide.valid && fillSide.ready;
  assign popFire = drainSide.valid && drainSide.ready;

  // next state of pointers and storage
  always_comb begin
    st_nxt = st_r;
    if (pushFire) begin
      st_nxt.mem[st_r.wrPtr] = fillSide.data;
      st_nxt.wrPtr = ~st_r.wrPtr;
    end
    if (popFire) begin
      st_nxt.rdPtr = ~st_r.rdPtr;
    end
    case ({pushFire, popFire})
      2'b10: st_nxt.count = st_r.count + 2'h1;
      2'b01: st_nxt.count = st_r.count - 2'h1;
      default: st_nxt.count = st_r.count;
    endcase
  end

  // state register
  always_ff @(posedge sys_clk or posedge arst) begin
    if (arst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  chk_fifo_bound: assert property (@(posedge sys_clk) disable iff (arst)
    st_r.count <= 2'h2) else $error("buffer count past two");
endmodule : drcb_fifo2
`default_nettype wire

// ### drcb_ctrl_model.sv
// controller-side model: link clock frames and data pins
// assumes: the link clock stands still between frames, driven from the bench
`timescale 1ns/10ps
`default_nettype none
module drcb_ctrl_model (
  output logic linkClk,
  output var logic [27:0] dataIn
);
  // idle pins at time zero
  initial begin
    linkClk = 1'b0;
    dataIn = 28'h0000000;
  end

  // one frame: data set up, rising edge, hold time, then idle tail
  task automatic send(input logic [27:0] w);
    dataIn = w;
    #40 linkClk = 1'b1;
    #40 dataIn = ~w; // stale pins no longer show the word
    #40 linkClk = 1'b0;
    #40;
  endtask : send

  // pins low around reset release
  task automatic quiet;
    dataIn = 28'h0000000;
  endtask : quiet
endmodule : drcb_ctrl_model
`default_nettype wire

// ### drcb_tb.sv
// self-checking bench for the registered command buffer
// assumes: drcb_top and drcb_ctrl_model compiled before this file
`timescale 1ns/10ps
`default_nettype none
module drcb_tb;
  logic sys_clk, rst, deviceResetN, secondChipSelectInN, fanoutSelect, abBankSelect, loadReady;
  logic linkClk;
  logic [27:0] dataIn;
  logic [13:0] copyAOut, copyBOut;
  logic wordValid, captureReady;
  int errorCnt = 0;
  int testsRun = 0;
  int k;

  drcb_ctrl_model drcb_ctrl_model_inst (.linkClk(linkClk), .dataIn(dataIn));
  drcb_top drcb_top_inst (.sys_clk(sys_clk), .rst(rst), .deviceResetN(deviceResetN), .linkClk(linkClk),
    .dataIn(dataIn), .secondChipSelectInN(secondChipSelectInN), .fanoutSelect(fanoutSelect),
    .abBankSelect(abBankSelect), .loadReady(loadReady), .copyAOut(copyAOut), .copyBOut(copyBOut),
    .wordValid(wordValid), .captureReady(captureReady));

  // ==========================================================
  // clock and common tasks
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic completeRun;
    $display("comparisons %0d mismatches %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : completeRun

  task automatic check(input string what, input logic [13:0] seen, input logic [13:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errorCnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  // wait for one output load, bounded
  task automatic waitWord;
    bit found;
    found = 1'b0;
    for (int i = 0; i < 60 && !found; i++) begin
      tick(1);
      found = (wordValid === 1'b1);
    end
    if (!found) begin
      errorCnt++;
      completeRun();
    end
  endtask : waitWord

  // straps change only inside a device reset
  task automatic setMode(input logic f, input logic b);
    bit up;
    deviceResetN = 1'b0;
    fanoutSelect = f;
    abBankSelect = b;
    drcb_ctrl_model_inst.quiet();
    tick(3);
    check("rstOut", copyAOut | copyBOut | {12'h000, wordValid, captureReady}, 14'h0000);
    deviceResetN = 1'b1;
    tick(1);
    check("relOut", copyAOut | copyBOut, 14'h0000);
    up = 1'b0;
    for (int i = 0; i < 20 && !up; i++) begin
      tick(1);
      up = (captureReady === 1'b1);
    end
    check("ready", {13'h0000, up}, 14'h0001);
  endtask : setMode

  // one frame, then the loaded outputs and the hold of copy A without edges
  task automatic xfer(input logic [27:0] w, input logic [13:0] ea, input logic [13:0] eb);
    fork
      drcb_ctrl_model_inst.send(w);
      waitWord();
    join
    check("copyA", copyAOut, ea);
    check("copyB", copyBOut, eb);
    tick(10);
    check("holdA", copyAOut, ea);
  endtask : xfer

  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    deviceResetN = 1'b0;
    secondChipSelectInN = 1'b0;
    fanoutSelect = 1'b0;
    abBankSelect = 1'b0;
    loadReady = 1'b1;
    repeat (8) @(posedge sys_clk);
    #1 rst = 1'b0;
    // one-to-one: straight map, unused last-column pads low, then freeze
    setMode(1'b0, 1'b0);
    xfer(28'hfffffff, 14'h3fff, 14'h3fb6);
    secondChipSelectInN = 1'b1;
    xfer(28'h0000040, drcb_pkg::GATE_A_MASK | 14'h0040, 14'h3fb6);
    secondChipSelectInN = 1'b0;
    xfer(28'h0000040, 14'h0040, 14'h0000);
    // one-to-two A: both copies equal, column two ignored
    setMode(1'b1, 1'b0);
    xfer(28'hfff1a5a, 14'h1a5a, 14'h1a5a);
    // stall: two words buffered, third refused
    loadReady = 1'b0;
    drcb_ctrl_model_inst.send(28'h0000123);
    drcb_ctrl_model_inst.send(28'h0000456);
    drcb_ctrl_model_inst.send(28'h0000789);
    check("fullRdy", {13'h0000, captureReady}, 14'h0000);
    loadReady = 1'b1;
    k = 0;
    for (int i = 0; i < 20; i++) begin
      tick(1);
      k += (wordValid === 1'b1) ? 1 : 0;
    end
    check("drained", 14'(k), 14'h0002);
    check("lastA", copyAOut, 14'h0456);
    // one-to-two B: moved control positions escape freezing
    setMode(1'b1, 1'b1);
    xfer(28'h0003fff, 14'h3fff, 14'h3fff);
    secondChipSelectInN = 1'b1;
    xfer(28'h0000040, drcb_pkg::GATE_B_MASK | 14'h0040, drcb_pkg::GATE_B_MASK | 14'h0040);
    // async reset between clock edges while frozen, then a frame during reset
    deviceResetN = 1'b0;
    #1 check("asyncA", copyAOut | copyBOut, 14'h0000);
    drcb_ctrl_model_inst.send(28'hfffffff);
    drcb_ctrl_model_inst.quiet();
    tick(1);
    deviceResetN = 1'b1;
    tick(12);
    check("noCapture", copyAOut | copyBOut, 14'h0000);
    completeRun();
  end
endmodule : drcb_tb
`default_nettype wire
